// file: verilog/fpec_ctrl.sv
// Flash program/erase control and status registers on Avalon-MM.
// Assumes one clock, synchronous active-low reset, pins asynchronous.
`include "fpec_consts.svh"

module fpec_ctrl #(
	parameter bit          HAS_PROT_PIN = 1'b1, // Protect pin fitted
	parameter bit          LARGE_ARRAY  = 1'b1, // 14 blocks, else 12
	parameter int unsigned NUM_BLOCKS   = 14    // Erase blocks
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// Avalon-MM slave
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	// Pins and device strapping
	input  wire logic        pin_write_enable,
	input  wire logic [2:0]  mode_pins,
	input  wire logic        flash_enabled,
	input  wire logic        high_map,
	// Flash array side
	input  wire logic        op_fail,
	input  wire logic [23:0] prog_addr,
	output logic [2:0]       flash_state,
	output logic [NUM_BLOCKS-1:0] erase_block_sel,
	output logic [23:0]      erase_base,
	output logic             overlay_active,
	output logic [2:0]       overlay_block,
	output logic             prog_addr_ok
);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic       pin_we_s;   // Synchronised protect pin
	logic [2:0] mode_s;     // Synchronised mode pins
	logic       fen_s;      // Synchronised flash enable
	logic       hmap_s;     // Synchronised map select
	logic       fail_s;     // Array failure, same clock

	fpec_sync u_sync_we (
		.clk       (clk),
		.rstn      (rstn),
		.pin_in    (pin_write_enable),
		.level_out (pin_we_s)
	);

	// Mode pins, flash enable and map select are straps
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_mode
			fpec_sync u_sync_md (
				.clk       (clk),
				.rstn      (rstn),
				.pin_in    (mode_pins[gi]),
				.level_out (mode_s[gi])
			);
		end
	endgenerate

	fpec_sync u_sync_fen (
		.clk       (clk),
		.rstn      (rstn),
		.pin_in    (flash_enabled),
		.level_out (fen_s)
	);

	fpec_sync u_sync_map (
		.clk       (clk),
		.rstn      (rstn),
		.pin_in    (high_map),
		.level_out (hmap_s)
	);

	assign fail_s = op_fail;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [6:0] ctrl_r;        // Mode control bits 6..0
	logic [6:0] ctrl_nxt;
	logic [7:0] small_r;       // Small block select
	logic [7:0] small_nxt;
	logic [7:0] large_r;       // Large block select
	logic [7:0] large_nxt;
	logic [3:0] ovl_r;         // Overlay select and area
	logic [3:0] ovl_nxt;
	logic       err_r;         // Operation error flag
	logic       ack_r;         // Access answered

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	wire        acc      = (avs_read | avs_write) & ~ack_r;
	// A write lands at the answering edge, the one where waitrequest is
	// low, so a master that holds its request never sees it land early
	wire        wr_en    = avs_write & ~avs_waitrequest & avs_byteenable[0];
	wire        sel_ctrl = (avs_address == 5'(`FPEC_OFS_MODE_CTRL));
	wire        sel_stat = (avs_address == 5'(`FPEC_OFS_OP_STATUS));
	wire        sel_sml  = (avs_address == 5'(`FPEC_OFS_ERASE_SMALL));
	wire        sel_lrg  = (avs_address == 5'(`FPEC_OFS_ERASE_LARGE));
	wire        sel_ovl  = (avs_address == `FPEC_OFS_OVERLAY);
	wire [7:0]  wd       = avs_writedata[7:0];

	// Pin-level enable as software sees it
	wire        mode_lo  = (mode_s == 3'h1) | (mode_s == 3'h2);
	wire        pin_bit  = HAS_PROT_PIN ? pin_we_s
	                                    : ~mode_lo;
	wire        sw_we    = ctrl_r[`FPEC_B_SW_WE];
	wire        both_en  = pin_bit & sw_we;
	// Overlay and error both lock the array out
	wire        locked   = err_r | ovl_r[`FPEC_B_OVL_SEL];

	// Select values after this cycle's write, before any clearing.
	// Built from the registers and the bus, not from the _nxt values,
	// so the multi-bit clear cannot feed back into itself.
	wire [7:0]  lrg_wd   = LARGE_ARRAY ? wd
	                                   : {wd[7:6], 2'b00, wd[3:0]};
	wire [7:0]  sml_cand = (wr_en && sel_sml) ? wd : small_r;
	wire [7:0]  lrg_cand = (wr_en && sel_lrg) ? lrg_wd : large_r;

	// Multiple-bit detect across both select registers
	wire [13:0] sel_all  = {lrg_cand[5:0], sml_cand};
	wire        multi    = (sel_all & (sel_all - 14'h1)) != 14'h0;

	// ----------------------------------------
	// Next-state of mode control
	// ----------------------------------------
	always_comb begin
		ctrl_nxt = ctrl_r;
		if (wr_en && sel_ctrl) begin
			ctrl_nxt[`FPEC_B_SW_WE] = wd[`FPEC_B_SW_WE];
			// Other bits settable only while enabled
			if (wd[`FPEC_B_SW_WE] && pin_bit) begin
				ctrl_nxt[5:2] = wd[5:2];
				// Go bits need their setup bit already set
				ctrl_nxt[`FPEC_B_ERS_GO] = wd[`FPEC_B_ERS_GO] &
					ctrl_r[`FPEC_B_ERS_SU] & ~err_r;
				ctrl_nxt[`FPEC_B_PRG_GO] = wd[`FPEC_B_PRG_GO] &
					ctrl_r[`FPEC_B_PRG_SU] & ~err_r;
			end else begin
				ctrl_nxt[5:0] = 6'h00;
			end
		end
		// Losing either enable clears the operating bits
		if (!pin_bit || !ctrl_nxt[`FPEC_B_SW_WE]) begin
			ctrl_nxt[5:0] = 6'h00;
		end
		// Cleared setup drops its go bit
		if (!ctrl_nxt[`FPEC_B_ERS_SU]) begin
			ctrl_nxt[`FPEC_B_ERS_GO] = 1'b0;
		end
		if (!ctrl_nxt[`FPEC_B_PRG_SU]) begin
			ctrl_nxt[`FPEC_B_PRG_GO] = 1'b0;
		end
	end

	// ----------------------------------------
	// Next-state of select registers
	// ----------------------------------------
	always_comb begin
		// Take the written value; bit 0 block 8, bits 1..5 blocks 9..13
		small_nxt = sml_cand;
		large_nxt = lrg_cand;
		if (multi) begin
			small_nxt = `FPEC_RST_BYTE;
			large_nxt[5:0] = 6'h00;
		end
		if (!ctrl_nxt[`FPEC_B_SW_WE]) begin
			small_nxt = `FPEC_RST_BYTE;
			large_nxt = `FPEC_RST_BYTE;
		end
	end

	// Overlay register next value
	always_comb begin
		ovl_nxt = ovl_r;
		if (wr_en && sel_ovl) begin
			ovl_nxt = wd[3:0];
		end
	end

	// ----------------------------------------
	// Register update
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ctrl_r  <= 7'h00;
			small_r <= `FPEC_RST_BYTE;
			large_r <= `FPEC_RST_BYTE;
			ovl_r   <= 4'h0;
		end else begin
			ctrl_r  <= ctrl_nxt;
			small_r <= small_nxt;
			large_r <= large_nxt;
			ovl_r   <= ovl_nxt;
		end
	end

	// Error flag: failure during program or erase; only reset clears.
	// The failure level comes from the array on this clock, so it is not
	// synchronised; a failure while no go bit is set is ignored.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			err_r <= 1'b0;
		end else if (fail_s && (ctrl_r[1] || ctrl_r[0])) begin
			err_r <= 1'b1;
		end
	end

	// ----------------------------------------
	// Bus answer: one wait cycle, then ack
	// ----------------------------------------
	// Read data is captured at the taking edge and stands through the
	// answering cycle; writes to the status register change nothing.
	logic [7:0] rd_byte;

	always_comb begin
		rd_byte = 8'h00;
		if (sel_ctrl) begin
			rd_byte = {pin_bit, ctrl_r};
		end else if (sel_stat) begin
			// Only the error flag; disabled flash reads zero
			rd_byte = fen_s ? {err_r, 7'h00} : 8'h00;
		end else if (sel_sml) begin
			rd_byte = small_r;
		end else if (sel_lrg) begin
			rd_byte = large_r;
		end else if (sel_ovl) begin
			rd_byte = {4'h0, ovl_r};
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			ack_r        <= 1'b0;
			avs_readdata <= 32'h0000_0000;
		end else begin
			ack_r        <= acc;
			if (acc && avs_read) begin
				avs_readdata <= {24'h00_0000, rd_byte};
			end
		end
	end

	// Waitrequest high until the ack cycle
	always_ff @(posedge clk) begin
		if (!rstn) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= ~acc;
		end
	end

	// ----------------------------------------
	// Flash state decode
	// ----------------------------------------
	fpec_pkg::fpec_state_t st_nxt;

	always_comb begin
		if (!pin_bit || locked) begin
			st_nxt = fpec_pkg::FPEC_PROTECT;
		end else if (ctrl_r[`FPEC_B_ERS_GO]) begin
			st_nxt = fpec_pkg::FPEC_ERASE;
		end else if (ctrl_r[`FPEC_B_PRG_GO]) begin
			st_nxt = fpec_pkg::FPEC_PROGRAM;
		end else if (ctrl_r[`FPEC_B_ERS_SU]) begin
			st_nxt = fpec_pkg::FPEC_ERS_SU;
		end else if (ctrl_r[`FPEC_B_PRG_SU]) begin
			st_nxt = fpec_pkg::FPEC_PRG_SU;
		end else if (ctrl_r[`FPEC_B_ERS_VFY]) begin
			st_nxt = fpec_pkg::FPEC_ERS_VFY;
		end else if (ctrl_r[`FPEC_B_PRG_VFY]) begin
			st_nxt = fpec_pkg::FPEC_PRG_VFY;
		end else begin
			st_nxt = fpec_pkg::FPEC_IDLE;
		end
	end

	// Block select in block order, cut to the array size
	wire [13:0] blk_vec = {large_r[5:0], small_r};
	wire [NUM_BLOCKS-1:0] blk_cut = blk_vec[NUM_BLOCKS-1:0];

	// ----------------------------------------
	// Registered outputs to the array
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			flash_state     <= 3'b000;
			erase_block_sel <= '0;
			erase_base      <= `FPEC_BASE_LOW;
			overlay_active  <= 1'b0;
			overlay_block   <= 3'h0;
			prog_addr_ok    <= 1'b0;
		end else begin
			flash_state     <= st_nxt;
			erase_block_sel <= blk_cut;
			erase_base      <= hmap_s ? `FPEC_BASE_HIGH
			                          : `FPEC_BASE_LOW;
			overlay_active  <= ovl_r[`FPEC_B_OVL_SEL];
			overlay_block   <= ovl_r[2:0];
			prog_addr_ok    <=
				(prog_addr & `FPEC_PUNIT_MASK) == 24'h0;
		end
	end

endmodule // fpec_ctrl

// file: verilog/fpec_consts.svh
// Constants for the flash program/erase control block.
// Assumes inclusion by bare name; definitions only.
`ifndef FPEC_CONSTS_SVH
`define FPEC_CONSTS_SVH

// ----------------------------------------
// Register byte addresses (Avalon word aligned)
// ----------------------------------------
`define FPEC_OFS_MODE_CTRL   4'h0
`define FPEC_OFS_OP_STATUS   4'h4
`define FPEC_OFS_ERASE_SMALL 4'h8
`define FPEC_OFS_ERASE_LARGE 4'hC
`define FPEC_OFS_OVERLAY     5'h10
`define FPEC_OFS_EVENT       5'h14

// ----------------------------------------
// Mode control field positions
// ----------------------------------------
`define FPEC_B_PIN_WE   7
`define FPEC_B_SW_WE    6
`define FPEC_B_ERS_SU   5
`define FPEC_B_PRG_SU   4
`define FPEC_B_ERS_VFY  3
`define FPEC_B_PRG_VFY  2
`define FPEC_B_ERS_GO   1
`define FPEC_B_PRG_GO   0

// Status and overlay fields
`define FPEC_B_ERR_FLAG 7
`define FPEC_B_OVL_SEL  3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define FPEC_RST_BYTE   8'h00
`define FPEC_LARGE_RSVD 8'hC0

// Address map bases of the two mode groups
`define FPEC_BASE_LOW   24'h000000
`define FPEC_BASE_HIGH  24'h100000

// Program unit is 128 bytes: low seven address bits zero
`define FPEC_PUNIT_MASK 24'h00007F

`endif

// file: verilog/fpec_pkg.sv
// Types for the flash program/erase control block.
// Assumes nothing of its surroundings.
package fpec_pkg;

	// Flash operating state seen by the array
	typedef enum logic [2:0] {
		FPEC_IDLE     = 3'b000,
		FPEC_ERS_SU   = 3'b001,
		FPEC_PRG_SU   = 3'b010,
		FPEC_ERASE    = 3'b011,
		FPEC_PROGRAM  = 3'b100,
		FPEC_ERS_VFY  = 3'b101,
		FPEC_PRG_VFY  = 3'b110,
		FPEC_PROTECT  = 3'b111
	} fpec_state_t;

endpackage

// file: verilog/fpec_sync.sv
// Two-flop synchroniser for one pin level.
// Assumes the pin is asynchronous to clk.
module fpec_sync (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rstn,
	// Pin and synchronised level
	input  wire logic pin_in,
	output logic      level_out
);

	logic meta_r;  // First stage, read only by second

	// ----------------------------------------
	// Two stages
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rstn) begin
			meta_r    <= 1'b0;
			level_out <= 1'b0;
		end else begin
			meta_r    <= pin_in;
			level_out <= meta_r;
		end
	end

endmodule // fpec_sync

// file: bench/fpec_ctrl_checker.sv
// Checker for the flash control block: bus answer and state relations.
// Assumes it is bound to fpec_ctrl and sees only its ports.
module fpec_ctrl_checker #(
	parameter int unsigned NUM_BLOCKS = 14 // Erase blocks
) (
	// Clock and reset
	input wire logic                  clk,
	input wire logic                  rstn,
	// Bus and pins
	input wire logic                  avs_read,
	input wire logic                  avs_write,
	input wire logic                  avs_waitrequest,
	input wire logic                  pin_write_enable,
	input wire logic                  high_map,
	input wire logic                  op_fail,
	input wire logic [23:0]           prog_addr,
	// Array side
	input wire logic [2:0]            flash_state,
	input wire logic [NUM_BLOCKS-1:0] erase_block_sel,
	input wire logic [23:0]           erase_base,
	input wire logic                  overlay_active,
	input wire logic                  prog_addr_ok
);
	// ----------------------------------------
	// Assertions, all in the one clock domain
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	a_wait_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	a_answer_bound: assert property ((avs_read || avs_write) && avs_waitrequest
		|-> ##[1:2] !avs_waitrequest) else $error("bus answer too late");
	a_sel_one_hot: assert property ($onehot0(erase_block_sel))
		else $error("more than one erase block selected");
	a_pin_protect: assert property (!pin_write_enable [*4] |=>
		flash_state == 3'h7) else $error("no protection with pin low");
	a_error_holds: assert property (op_fail &&
		flash_state inside {3'h3, 3'h4} |-> ##3 (flash_state == 3'h7) [*8])
		else $error("failure did not hold protection");
	a_base_high: assert property (high_map [*5] |->
		erase_base == 24'h100000) else $error("high map base wrong");
	a_base_low: assert property (!high_map [*5] |->
		erase_base == 24'h000000) else $error("low map base wrong");
	a_prog_align: assert property (1'b1 |=> prog_addr_ok ==
		(($past(prog_addr) & 24'h00007F) == 24'h000000))
		else $error("program unit alignment flag wrong");
	a_overlay_protect: assert property (overlay_active [*2] |->
		flash_state == 3'h7) else $error("overlay without protection");
endmodule // fpec_ctrl_checker

bind fpec_ctrl fpec_ctrl_checker #(.NUM_BLOCKS(NUM_BLOCKS)) fpec_ctrl_checker_i (
	.clk, .rstn, .avs_read, .avs_write, .avs_waitrequest, .pin_write_enable,
	.high_map, .op_fail, .prog_addr, .flash_state, .erase_block_sel,
	.erase_base, .overlay_active, .prog_addr_ok);

// file: bench/tb_fpec_ctrl.sv
// Testbench for the flash control block: register calls with expectations.
// Assumes default parameters: protect pin fitted, 14 erase blocks.
module tb_fpec_ctrl;
	timeunit 1ns;
	timeprecision 100ps;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic [4:0]  avs_address = 5'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        pin_write_enable = 1'b1;
	logic        flash_enabled = 1'b1;
	logic        high_map = 1'b0;
	logic        op_fail = 1'b0;
	logic [23:0] prog_addr = 24'h0;
	logic [2:0]  flash_state;
	logic [13:0] erase_block_sel;
	logic [23:0] erase_base;
	logic        overlay_active;
	logic [2:0]  overlay_block;
	logic        prog_addr_ok;
	logic [31:0] rd;
	logic [31:0] rd_b;            // Read data of the pinless variant
	logic [31:0] avs_readdata_b;
	logic [2:0]  mode_b = 3'h1;   // Mode pins of the pinless variant
	int          fails = 0;
	int          num_checks = 0;
	// Control writes and the state each should give
	logic [7:0]  seq_d [9] = '{8'h60, 8'h62, 8'h60, 8'h50, 8'h51, 8'h50,
		8'h48, 8'h44, 8'h40};
	logic [2:0]  seq_s [9] = '{3'h1, 3'h3, 3'h1, 3'h2, 3'h4, 3'h2,
		3'h5, 3'h6, 3'h0};

	always #2.5 clk = ~clk;

	fpec_ctrl fpec_ctrl_i (.clk, .rstn, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest,
		.pin_write_enable, .mode_pins(3'h3), .flash_enabled, .high_map, .op_fail,
		.prog_addr, .flash_state, .erase_block_sel, .erase_base, .overlay_active,
		.overlay_block, .prog_addr_ok);

	// Pinless 256-kbyte variant on the same bus; its reads are compared too
	fpec_ctrl #(.HAS_PROT_PIN(1'b0), .LARGE_ARRAY(1'b0), .NUM_BLOCKS(12))
		fpec_ctrl_small_i (.clk, .rstn, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable(4'hF), .avs_readdata(avs_readdata_b),
		.avs_waitrequest(), .pin_write_enable(1'b1), .mode_pins(mode_b),
		.flash_enabled, .high_map(1'b0), .op_fail(1'b0), .prog_addr(24'h0),
		.flash_state(), .erase_block_sel(), .erase_base(), .overlay_active(),
		.overlay_block(), .prog_addr_ok());

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Bus write, held until waitrequest is sampled low
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk);
		avs_address   <= a;
		avs_writedata <= {24'h000000, d};
		avs_write     <= 1'b1;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
	endtask

	// Bus read, data taken at the answering edge, then compared
	task automatic rchk(input logic [4:0] a, input logic [7:0] exp);
		@(posedge clk);
		avs_address <= a;
		avs_read    <= 1'b1;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		rd_b = avs_readdata_b;
		avs_read <= 1'b0;
		chk($sformatf("reg_%h", a), rd, {24'h000000, exp});
	endtask

	// State compare once the registered state has settled
	task automatic st(input logic [2:0] exp);
		repeat (2) @(posedge clk);
		chk("state", {29'h0, flash_state}, {29'h0, exp});
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		complete_run();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		rchk(5'h00, 8'h80);
		chk("ctrl_b", rd_b, 32'h00);
		mode_b <= 3'h3;
		rchk(5'h04, 8'h00);
		rchk(5'h18, 8'h00);
		wr(5'h00, 8'h3F);
		rchk(5'h00, 8'h80);
		wr(5'h08, 8'h01);
		rchk(5'h08, 8'h00);
		wr(5'h00, 8'h40);
		for (int n = 0; n < 8; n++) begin
			wr(5'h08, 8'h01 << n);
			rchk(5'h08, 8'h01 << n);
			chk("sel", {18'h0, erase_block_sel}, 32'h1 << n);
		end
		// Second select bit clears both registers
		wr(5'h0C, 8'h01);
		rchk(5'h08, 8'h00);
		rchk(5'h0C, 8'h00);
		for (int n = 0; n < 6; n++) begin
			wr(5'h0C, 8'h01 << n);
			repeat (2) @(posedge clk);
			chk("sel", {18'h0, erase_block_sel}, 32'h100 << n);
		end
		rchk(5'h0C, 8'h20);
		chk("large_b", rd_b, 32'h00);
		wr(5'h00, 8'h00);
		rchk(5'h0C, 8'h00);
		wr(5'h00, 8'h40);
		wr(5'h00, 8'h42);
		rchk(5'h00, 8'hC0);
		chk("ctrl_b", rd_b, 32'hC0);
		for (int i = 0; i < 9; i++) begin
			wr(5'h00, seq_d[i]);
			st(seq_s[i]);
		end
		// Pin low: protection and refused setup
		pin_write_enable <= 1'b0;
		repeat (3) @(posedge clk);
		st(3'h7);
		wr(5'h00, 8'h60);
		rchk(5'h00, 8'h40);
		pin_write_enable <= 1'b1;
		wr(5'h10, 8'h0D);
		st(3'h7);
		chk("ovl", {28'h0, overlay_active, overlay_block}, 32'hD);
		wr(5'h10, 8'h00);
		st(3'h0);
		high_map <= 1'b1;
		repeat (6) @(posedge clk);
		chk("base", {8'h00, erase_base}, 32'h100000);
		high_map <= 1'b0;
		prog_addr <= 24'h000180;
		repeat (3) @(posedge clk);
		chk("align", {31'h0, prog_addr_ok}, 32'h1);
		prog_addr <= 24'h0001C1;
		repeat (3) @(posedge clk);
		chk("align", {31'h0, prog_addr_ok}, 32'h0);
		// Failure in program mode, then retry refused
		wr(5'h00, 8'h50);
		wr(5'h00, 8'h51);
		st(3'h4);
		op_fail <= 1'b1;
		@(posedge clk);
		op_fail <= 1'b0;
		st(3'h7);
		rchk(5'h04, 8'h80);
		wr(5'h00, 8'h40);
		wr(5'h00, 8'h50);
		wr(5'h00, 8'h51);
		rchk(5'h00, 8'hD0);
		st(3'h7);
		flash_enabled <= 1'b0;
		repeat (3) @(posedge clk);
		rchk(5'h04, 8'h00);
		complete_run();
	end
endmodule // tb_fpec_ctrl
